// ==== include/abn_pkg.sv ====
// Constants for the ABN quadrature encoder counter block.
// Assumes an AXI4-Lite master with 32-bit data and one 200 MHz clock.
//
// Contract
// R01: Encoder position is a signed 32-bit counter, host readable and writable.
// R02: Signed 16.16 constant is added or subtracted per count; sign sets direction.
// R03: Decimal-select bit 10 low: fraction counts in units of 1/65536.
// R04: Decimal-select bit 10 high: fraction counts in units of 1/10000.
// R05: Scale constant resets to 1.0, raw value 65536.
// R06: Status bit 0 index event, bit 1 deviation; cleared by writing one.
// R07: Deviation flag clear is ignored while the deviation persists.
// R08: Both status flags are ORed onto the interrupt output.
// R09: Deviation warning when count differs from ramp by over limit; zero disables.
// R10: Qualifying index event copies position into the capture register.
// R11: Mode bit 9 also captures ramp position on that same index event.
// R12: Mode bit 8 clear latches only; set latches then zeroes the counter.
// R13: Mode bits 7:6 pick level, active edge, inactive edge or both edges.
// R14: Mode bit 5 acts only on the first index event after the write.
// R15: Mode bit 4 acts on every index event.
// R16: Mode bit 3 low: event needs N, A and B at their set polarities.
// R17: Mode bit 2 sets index active level, one meaning high active.
// R18: Mode bits 1 and 0 give required B and A levels.
// R19: Ramp latch register holds a snapshot of the ramp actual position.
// R20: Mode bit 3 high: index qualified by N alone.
// R21: A, B, N are synchronised and quadrature transitions count up or down.
package abn_pkg;

    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index.
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_RAMP_LATCH  = 6'h36;
    localparam logic [5:0] IDX_MODE        = 6'h38;
    localparam logic [5:0] IDX_POSITION    = 6'h39;
    localparam logic [5:0] IDX_SCALE       = 6'h3A;
    localparam logic [5:0] IDX_FLAGS       = 6'h3B;
    localparam logic [5:0] IDX_CAPTURE     = 6'h3C;
    localparam logic [5:0] IDX_DEV_LIMIT   = 6'h3D;

    // ----------------------------------------------------------------
    // Mode register field positions.
    // ----------------------------------------------------------------
    localparam int MODE_W          = 11;
    localparam int MB_POL_A        = 0;
    localparam int MB_POL_B        = 1;
    localparam int MB_POL_N        = 2;
    localparam int MB_SKIP_QUAD    = 3;
    localparam int MB_CLR_CONT     = 4;
    localparam int MB_CLR_ONCE     = 5;
    localparam int MB_POS_EDGE     = 6;
    localparam int MB_NEG_EDGE     = 7;
    localparam int MB_CLR_POS      = 8;
    localparam int MB_LATCH_RAMP   = 9;
    localparam int MB_DECIMAL      = 10;

    // Status flag positions.
    localparam int FB_INDEX        = 0;
    localparam int FB_DEVIATION    = 1;

    // ----------------------------------------------------------------
    // Reset values and arithmetic constants.
    // ----------------------------------------------------------------
    localparam logic [31:0] SCALE_RESET  = 32'h0001_0000;
    localparam logic [16:0] FRAC_MOD_BIN = 17'h1_0000;
    localparam logic [16:0] FRAC_MOD_DEC = 17'h0_2710;
    localparam int          DEV_LIMIT_W  = 20;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== hw/abn_encoder_counter.sv ====
// ABN quadrature encoder counter with index latch and deviation check.
// Assumes an AXI4-Lite master on aclk and a ramp generator on the same clock.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps

module abn_encoder_counter
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_n,
    input  wire logic [31:0] ramp_actual_position,
    output logic             irq
);

    // ----------------------------------------------------------------
    // State.
    // ----------------------------------------------------------------
    logic [abn_pkg::MODE_W-1:0]      encoder_mode_cfg;
    logic [31:0]                     encoder_position;
    logic [15:0]                     frac_acc;
    logic [31:0]                     encoder_scale_constant;
    logic [1:0]                      encoder_event_flags;
    logic [31:0]                     encoder_capture_position;
    logic [abn_pkg::DEV_LIMIT_W-1:0] encoder_deviation_limit;
    logic [31:0]                     ramp_position_latch;
    logic                            once_armed;
    logic [2:0]                      pin_s1;
    logic [2:0]                      pin_s2;
    logic [2:0]                      pin_s3;
    logic [2:0]                      pin_f;
    logic [2:0]                      pin_prev;
    logic                            qual_prev;
    logic [7:0]                      wr_addr;
    logic [31:0]                     wr_data;
    logic [3:0]                      wr_strb;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Bus decode.
    // ----------------------------------------------------------------
    wire       aw_hs    = s_axi_awvalid && s_axi_awready;
    wire       w_hs     = s_axi_wvalid && s_axi_wready;
    wire       ar_hs    = s_axi_arvalid && s_axi_arready;
    wire       do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire [5:0] wr_idx   = wr_addr[7:2];
    wire [5:0] rd_idx   = s_axi_araddr[7:2];
    wire       wr_mode  = do_write && wr_idx == abn_pkg::IDX_MODE;
    wire       wr_pos   = do_write && wr_idx == abn_pkg::IDX_POSITION;
    wire       wr_scale = do_write && wr_idx == abn_pkg::IDX_SCALE;
    wire       wr_flags = do_write && wr_idx == abn_pkg::IDX_FLAGS;
    wire       wr_limit = do_write && wr_idx == abn_pkg::IDX_DEV_LIMIT;
    wire       wr_hit   = wr_idx == abn_pkg::IDX_MODE || wr_idx == abn_pkg::IDX_POSITION
                       || wr_idx == abn_pkg::IDX_SCALE || wr_idx == abn_pkg::IDX_FLAGS
                       || wr_idx == abn_pkg::IDX_DEV_LIMIT || wr_idx == abn_pkg::IDX_CAPTURE
                       || wr_idx == abn_pkg::IDX_RAMP_LATCH;
    wire [31:0] wr_word = merge_bytes(32'h0000_0000, wr_data, wr_strb);
    wire [31:0] mode_w  = merge_bytes({21'h0, encoder_mode_cfg}, wr_data, wr_strb);
    wire [31:0] pos_w   = merge_bytes(encoder_position, wr_data, wr_strb);
    wire [31:0] scale_w = merge_bytes(encoder_scale_constant, wr_data, wr_strb);
    wire [31:0] lim_w   = merge_bytes({12'h0, encoder_deviation_limit}, wr_data, wr_strb);

    // Write-only registers read back as zero.
    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (rd_idx)
            abn_pkg::IDX_MODE:       rd_word = {21'h0, encoder_mode_cfg};
            abn_pkg::IDX_POSITION:   rd_word = encoder_position;
            abn_pkg::IDX_FLAGS:      rd_word = {30'h0, encoder_event_flags};
            abn_pkg::IDX_CAPTURE:    rd_word = encoder_capture_position;
            abn_pkg::IDX_RAMP_LATCH: rd_word = ramp_position_latch;
            abn_pkg::IDX_SCALE:      rd_word = 32'h0000_0000;
            abn_pkg::IDX_DEV_LIMIT:  rd_word = 32'h0000_0000;
            default:                 rd_hit  = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and quadrature decode.
    // ----------------------------------------------------------------
    wire [2:0] pin_raw = {enc_n, enc_b, enc_a};
    // A pin only changes once the second and third stages agree.
    wire [2:0] next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
    wire       a_f  = pin_f[0];
    wire       b_f  = pin_f[1];
    wire       n_f  = pin_f[2];
    wire       step = (a_f ^ pin_prev[0]) ^ (b_f ^ pin_prev[1]);      // [R21]
    // A leading B counts up: 00, 10, 11, 01.
    wire       up   = pin_prev[0] == b_f;                               // [R21]

    // ----------------------------------------------------------------
    // Scaled accumulation.
    // ----------------------------------------------------------------
    wire        dec_mode = encoder_mode_cfg[abn_pkg::MB_DECIMAL];
    wire [16:0] frac_mod = dec_mode ? abn_pkg::FRAC_MOD_DEC          // [R04]
                                    : abn_pkg::FRAC_MOD_BIN;         // [R03]
    wire        c_neg    = encoder_scale_constant[31];
    // Working on the magnitude lets binary and decimal share one datapath.
    wire [31:0] c_mag    = c_neg ? 32'(-encoder_scale_constant) : encoder_scale_constant;
    wire        add      = up ^ c_neg;                                  // [R02]
    wire [16:0] sum_f    = {1'b0, frac_acc} + {1'b0, c_mag[15:0]};
    wire        carry    = sum_f >= frac_mod;
    wire [16:0] frac_up  = carry ? sum_f - frac_mod : sum_f;
    wire [16:0] dif_f    = {1'b0, frac_acc} - {1'b0, c_mag[15:0]};
    wire        borrow   = dif_f[16];
    wire [16:0] frac_dn  = borrow ? dif_f + frac_mod : dif_f;
    wire [31:0] pos_up   = encoder_position + {16'h0, c_mag[31:16]} + {31'h0, carry};
    wire [31:0] pos_dn   = encoder_position - {16'h0, c_mag[31:16]} - {31'h0, borrow};

    // ----------------------------------------------------------------
    // Index qualification.
    // ----------------------------------------------------------------
    wire n_active = n_f == encoder_mode_cfg[abn_pkg::MB_POL_N];            // [R17]
    wire ab_match = a_f == encoder_mode_cfg[abn_pkg::MB_POL_A]
                 && b_f == encoder_mode_cfg[abn_pkg::MB_POL_B];            // [R18]
    wire qual     = n_active && (encoder_mode_cfg[abn_pkg::MB_SKIP_QUAD]  // [R20]
                                 || ab_match);                             // [R16]
    wire pos_sel  = encoder_mode_cfg[abn_pkg::MB_POS_EDGE];
    wire neg_sel  = encoder_mode_cfg[abn_pkg::MB_NEG_EDGE];
    wire n_evt    = (!pos_sel && !neg_sel) ? qual                          // [R13]
                  : ((pos_sel && qual && !qual_prev)
                     || (neg_sel && !qual && qual_prev));                  // [R13]
    wire act      = n_evt && (encoder_mode_cfg[abn_pkg::MB_CLR_CONT]     // [R15]
                              || once_armed);                              // [R14]
    wire clr_pos  = act && encoder_mode_cfg[abn_pkg::MB_CLR_POS];         // [R12]

    // ----------------------------------------------------------------
    // Deviation check.
    // ----------------------------------------------------------------
    wire [32:0] dev_diff = {encoder_position[31], encoder_position}
                         - {ramp_actual_position[31], ramp_actual_position};
    wire [32:0] dev_abs  = dev_diff[32] ? 33'(-dev_diff) : dev_diff;
    wire        dev_cond = encoder_deviation_limit != '0
                        && dev_abs > {13'h0, encoder_deviation_limit};     // [R09]

    // Set wins over a write-one clear on both flags.
    wire [1:0] flag_clr  = wr_flags ? wr_word[1:0] : 2'b00;
    wire [1:0] next_flags =
        {dev_cond || (encoder_event_flags[abn_pkg::FB_DEVIATION]
                      && !(flag_clr[abn_pkg::FB_DEVIATION] && !dev_cond)),  // [R07]
         n_evt || (encoder_event_flags[abn_pkg::FB_INDEX]
                   && !flag_clr[abn_pkg::FB_INDEX])};                      // [R06]

    // ----------------------------------------------------------------
    // AXI4-Lite handshakes.
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= abn_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= abn_pkg::RESP_OKAY;
            wr_addr       <= 8'h00;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end
        else if (ce)
        begin
            if (aw_hs)
            begin
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? abn_pkg::RESP_OKAY : abn_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (ar_hs)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? abn_pkg::RESP_OKAY : abn_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers.
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            encoder_mode_cfg        <= '0;
            encoder_scale_constant  <= abn_pkg::SCALE_RESET;            // [R05]
            encoder_deviation_limit <= '0;
        end
        else if (ce)
        begin
            if (wr_mode)
            begin
                encoder_mode_cfg <= mode_w[abn_pkg::MODE_W-1:0];
            end
            if (wr_scale)
            begin
                encoder_scale_constant <= scale_w;
            end
            if (wr_limit)
            begin
                encoder_deviation_limit <= lim_w[abn_pkg::DEV_LIMIT_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pins, counter, latches and flags.
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1    <= 3'h0;
            pin_s2    <= 3'h0;
            pin_s3    <= 3'h0;
            pin_f     <= 3'h0;
            pin_prev  <= 3'h0;
            qual_prev <= 1'b0;
        end
        else if (ce)
        begin
            pin_s1    <= pin_raw;
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            pin_f     <= next_pin_f;
            pin_prev  <= pin_f;
            qual_prev <= qual;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            encoder_position <= 32'h0000_0000;
            frac_acc         <= 16'h0000;
        end
        else if (ce)
        begin
            // A host write of the position takes priority over index clearing.
            if (wr_pos)
            begin
                encoder_position <= pos_w;                                // [R01]
                frac_acc         <= 16'h0000;
            end
            else if (clr_pos)
            begin
                encoder_position <= 32'h0000_0000;                        // [R12]
                frac_acc         <= 16'h0000;
            end
            else if (step)
            begin
                encoder_position <= add ? pos_up : pos_dn;                // [R02]
                frac_acc         <= add ? frac_up[15:0] : frac_dn[15:0];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            encoder_capture_position <= 32'h0000_0000;
            ramp_position_latch      <= 32'h0000_0000;
            once_armed               <= 1'b0;
            encoder_event_flags      <= 2'b00;
            irq                      <= 1'b0;
        end
        else if (ce)
        begin
            if (act)
            begin
                encoder_capture_position <= encoder_position;             // [R10]
            end
            if (act && encoder_mode_cfg[abn_pkg::MB_LATCH_RAMP])
            begin
                ramp_position_latch <= ramp_actual_position;              // [R11] [R19]
            end
            if (wr_mode)
            begin
                once_armed <= mode_w[abn_pkg::MB_CLR_ONCE];               // [R14]
            end
            else if (act)
            begin
                once_armed <= 1'b0;                                       // [R14]
            end
            encoder_event_flags <= next_flags;                            // [R06]
            irq                 <= |encoder_event_flags;                   // [R08]
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    a_scale_reset: assert property (@(posedge aclk)                       // [R05]
        $rose(aresetn) |-> encoder_scale_constant == abn_pkg::SCALE_RESET)
        else $error("Scale constant not 1.0 after reset.");

    a_irq_or_flags: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
        ce |=> irq == $past(encoder_event_flags[0] | encoder_event_flags[1]))
        else $error("Interrupt does not follow status flags.");

    a_dev_clear_held: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
        (ce && dev_cond && encoder_event_flags[1]) |=> encoder_event_flags[1])
        else $error("Deviation flag cleared while deviation persists.");

    a_dev_limit_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
        encoder_deviation_limit == '0 |-> !dev_cond)
        else $error("Deviation reported with limit zero.");

    a_capture_pos: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        (ce && act) |=> encoder_capture_position == $past(encoder_position))
        else $error("Capture register missed the position.");

    a_clear_on_index: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        (ce && clr_pos && !wr_pos) |=> encoder_position == 32'h0000_0000)
        else $error("Counter not cleared on index.");

    a_ramp_capture: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        (ce && act && encoder_mode_cfg[abn_pkg::MB_LATCH_RAMP])
        |=> ramp_position_latch == $past(ramp_actual_position))
        else $error("Ramp position not latched with encoder.");

    a_once_single: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
        (ce && act && !wr_mode) |=> !once_armed)
        else $error("Single-shot index stayed armed.");

    a_index_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
        (ce && n_evt) |=> encoder_event_flags[0])
        else $error("Index flag not set on event.");

    a_unit_step: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
        (ce && step && up && !wr_pos && !clr_pos && !dec_mode
         && encoder_scale_constant == abn_pkg::SCALE_RESET)
        |=> encoder_position == $past(encoder_position) + 32'h0000_0001)
        else $error("Unit scale step did not add one.");

endmodule

// ==== sim/abn_enc_model.sv ====
// Behavioural incremental ABN encoder on the motor shaft.
// Assumes the bench calls move and pulse_n; the pins are push-pull levels.
`timescale 1ns/1ps

module abn_enc_model
(
    input  wire logic aclk,
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_n
);
    logic [1:0] phase = 2'b00;
    // Gray order 00,10,11,01 puts A ahead of B when turning forward.
    assign enc_a = phase[1] ^ phase[0];
    assign enc_b = phase[1];
    initial enc_n = 1'b0;
    // Each state is held 8 cycles, so only one line changes per filter delay.
    task automatic move(input int n);
        repeat (n < 0 ? -n : n)
        begin
            repeat (8) @(posedge aclk);
            phase <= (n < 0) ? phase - 2'd1 : phase + 2'd1;
        end
        repeat (8) @(posedge aclk);
    endtask
    task automatic pulse_n;
        @(posedge aclk);
        enc_n <= 1'b1;
        repeat (8) @(posedge aclk);
        enc_n <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the ABN encoder counter, driven over AXI4-Lite.
// Assumes abn_pkg is compiled first and abn_enc_model turns the shaft.
`timescale 1ns/1ps

module tb_top;
    localparam logic [7:0] A_LATCH = {abn_pkg::IDX_RAMP_LATCH, 2'b00};
    localparam logic [7:0] A_MODE  = {abn_pkg::IDX_MODE, 2'b00};
    localparam logic [7:0] A_POS   = {abn_pkg::IDX_POSITION, 2'b00};
    localparam logic [7:0] A_SCALE = {abn_pkg::IDX_SCALE, 2'b00};
    localparam logic [7:0] A_FLAGS = {abn_pkg::IDX_FLAGS, 2'b00};
    localparam logic [7:0] A_CAPT  = {abn_pkg::IDX_CAPTURE, 2'b00};
    localparam logic [7:0] A_LIMIT = {abn_pkg::IDX_DEV_LIMIT, 2'b00};
    logic        aclk = 1'b0;
    logic        aresetn, awvalid, wvalid, bready, arvalid, rready, enc_a, enc_b, enc_n;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, ramp, d;
    logic [1:0]  bresp, rresp, r;
    logic        ce;
    logic [3:0]  strb;
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;
    always #2.5 aclk = ~aclk;
    abn_encoder_counter uut
    (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
        .ramp_actual_position(ramp), .irq(irq)
    );
    abn_enc_model enc (.aclk(aclk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));
    task automatic end_sim(input int bad);
        err_count = err_count + bad;
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Handshakes are sampled at the rising edge, before the design's own updates land.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task automatic cr(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
            end_sim(1);
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {ce, strb} = 5'h1F;
        {awaddr, araddr, wdata, ramp} = 80'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        enc.move(4);
        cr(A_POS, 32'h0000_0004);
        enc.move(-6);
        cr(A_POS, 32'hFFFF_FFFE);
        wr(A_POS, 32'h7FFF_FFFF);
        enc.move(1);
        cr(A_POS, 32'h8000_0000);
        wr(A_POS, 32'h0000_0000);
        wr(A_SCALE, 32'h0002_8000);
        enc.move(3);
        cr(A_POS, 32'h0000_0007);
        wr(A_MODE, 32'h0000_0400);
        wr(A_POS, 32'h0000_0000);
        wr(A_SCALE, 32'h0001_1388);
        enc.move(3);
        cr(A_POS, 32'h0000_0004);
        wr(A_POS, 32'h0000_0000);
        wr(A_SCALE, 32'hFFFE_0000);
        enc.move(2);
        cr(A_POS, 32'hFFFF_FFFC);
        wr(A_SCALE, 32'h0001_0000);
        wr(A_MODE, 32'h0000_035C);
        wr(A_FLAGS, 32'h0000_0001);
        ramp <= 32'h0000_1234;
        wr(A_POS, 32'h0000_0064);
        enc.pulse_n();
        cr(A_CAPT, 32'h0000_0064);
        cr(A_POS, 32'h0000_0000);
        cr(A_LATCH, 32'h0000_1234);
        cr(A_FLAGS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(A_FLAGS, 32'h0000_0001);
        cr(A_FLAGS, 32'h0000_0000);
        wr(A_MODE, 32'h0000_0167);
        wr(A_POS, 32'h0000_0032);
        enc.pulse_n();
        cr(A_POS, 32'h0000_0032);
        enc.move(-1);
        enc.pulse_n();
        cr(A_CAPT, 32'h0000_0031);
        wr(A_POS, 32'h0000_0007);
        enc.pulse_n();
        cr(A_POS, 32'h0000_0007);
        ramp <= 32'h0000_000A;
        wr(A_POS, 32'h0000_0004);
        wr(A_LIMIT, 32'h0000_0005);
        wr(A_FLAGS, 32'h0000_0003);
        cr(A_FLAGS, 32'h0000_0002);
        wr(A_POS, 32'h0000_0005);
        wr(A_FLAGS, 32'h0000_0002);
        cr(A_FLAGS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(A_LIMIT, 32'h0000_0000);
        wr(A_POS, 32'h0000_0064);
        cr(A_FLAGS, 32'h0000_0000);
        strb <= 4'h2;
        wr(A_POS, 32'h0000_1200);
        strb <= 4'hF;
        cr(A_POS, 32'h0000_1264);
        // Both quadrature lines move while frozen, so the thawed filter sees no single step.
        ce <= 1'b0;
        enc.move(2);
        ce <= 1'b1;
        cr(A_POS, 32'h0000_1264);
        rd(8'h00);
        chk({30'h0, r}, {30'h0, abn_pkg::RESP_SLVERR});
        end_sim(0);
    end
endmodule
